// file: hdl/cis_pkg.sv
// constants and carriers shared by the capture input conditioning block
// assumes a single 200 MHz clock and 32-bit apb register access
package cis_pkg;
    // clock and sampling timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SAMPLE_PERIOD_NS = 40;
    localparam int SAMPLE_DIV = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_DIV - 1);
    localparam int FILT_SAMPLES = 5;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] CNT_OFS = 8'h0c;
    localparam logic [7:0] CAPR_OFS = 8'h10;
    localparam logic [7:0] CAPF_OFS = 8'h14;
    localparam logic [7:0] LVL_OFS = 8'h18;
    // field positions and reset values
    localparam int CTRL_W = 7;
    localparam int STAT_CAP_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [7:0] CNT_RST = 8'h00;
    // prescaler tap masks: divide by 64, 32, 2, 1
    localparam logic [5:0] DIV64_MASK = 6'h3f;
    localparam logic [5:0] DIV32_MASK = 6'h1f;
    localparam logic [5:0] DIV2_MASK = 6'h01;
    localparam logic [5:0] DIV1_MASK = 6'h00;

    typedef enum logic [1:0] {
        CIS_DIV64 = 2'b00,
        CIS_DIV32 = 2'b01,
        CIS_DIV2 = 2'b10,
        CIS_DIV1 = 2'b11
    } cis_div_e;

    // capture_timer_mode plus port mode bits, most significant first
    typedef struct packed {
        cis_div_e clk_sel;
        logic counter_clear_select_hi;
        logic counter_clear_select_lo;
        logic capture_irq_edge_select;
        logic noise_filter_select;
        logic capture_pin_select;
    } cis_ctrl_s;
endpackage

// file: hdl/cis_sync.sv
// two-stage synchroniser for the capture pin
// assumes the pin is asynchronous to pclk
`timescale 1ns/10ps
module cis_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// file: hdl/cis_filter.sv
// noise filter: a level passes once five consecutive samples agree
// assumes din is already synchronised to pclk
`timescale 1ns/10ps
module cis_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    input wire logic enable,
    output logic filt_out
);
    logic [3:0] div_reg;
    logic tick;
    logic [cis_pkg::FILT_SAMPLES-1:0] shift_reg;
    logic [cis_pkg::FILT_SAMPLES-1:0] shift_next;

    // sampling clock derived from pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 4'h0;
        end else if (div_reg == cis_pkg::SAMPLE_LAST) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end
    assign tick = (div_reg == cis_pkg::SAMPLE_LAST);
    assign shift_next = {shift_reg[cis_pkg::FILT_SAMPLES-2:0], din};

    // bypassed filter tracks the pin, so a later enable starts clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= '0;
            filt_out <= 1'b0;
        end else if (!enable) begin
            shift_reg <= {cis_pkg::FILT_SAMPLES{din}};
            filt_out <= din;
        end else if (tick) begin
            shift_reg <= shift_next;
            if (&shift_next) begin
                filt_out <= 1'b1;
            end else if (~|shift_next) begin
                filt_out <= 1'b0;
            end
        end
    end

    AST_FILT_FIVE: assert property (@(posedge pclk) disable iff (!presetn)
        enable && $past(enable) && $changed(filt_out)
        |-> $past(tick) && shift_reg == {cis_pkg::FILT_SAMPLES{filt_out}})
        else $error("filter output changed before five samples");
endmodule

// file: hdl/cis_capture.sv
// capture input conditioning with an 8-bit capture timer and apb registers
// assumes an apb3 master on pclk and an asynchronous capture pin
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module cis_capture (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shared_capture_port_pin,
    output logic capture_signal,
    output logic irq
);
    cis_pkg::cis_ctrl_s ctrl_reg;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] mask_reg;
    logic [7:0] count_reg;
    logic [7:0] cap_rise_reg;
    logic [7:0] cap_fall_reg;
    logic [5:0] pre_reg;
    logic [5:0] div_mask;
    logic count_tick;
    logic pin_sync;
    logic pin_filt;
    logic src_lvl;
    logic cap_sig_next;
    logic cap_sig_reg;
    logic rise_evt;
    logic fall_evt;
    logic cap_evt;
    logic ovf_evt;
    logic clr_evt;
    logic setup_rd;
    logic acc;
    logic acc_wr;
    logic stat_rd;
    logic hit;
    logic [31:0] rdata_next;

    // true when the bus address selects the given register
    function automatic logic reg_is(input logic [7:0] addr,
                                    input logic [7:0] ofs);
        reg_is = (addr == ofs);
    endfunction

    cis_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(shared_capture_port_pin),
        .sync_out(pin_sync)
    );

    cis_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .din(pin_sync),
        .enable(ctrl_reg.noise_filter_select),
        .filt_out(pin_filt)
    );

    // source mux then gate; a select or filter change can itself
    // move the gated level, which is seen as an edge by design
    assign src_lvl = ctrl_reg.noise_filter_select ? pin_filt
                                                  : pin_sync;
    assign cap_sig_next = ctrl_reg.capture_pin_select & src_lvl;
    assign rise_evt = cap_sig_next & ~cap_sig_reg;
    assign fall_evt = ~cap_sig_next & cap_sig_reg;
    assign cap_evt = ctrl_reg.capture_irq_edge_select ? rise_evt
                                                      : fall_evt;

    // edges are detected on the gated signal, never on the raw pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sig_reg <= 1'b0;
        end else begin
            cap_sig_reg <= cap_sig_next;
        end
    end
    assign capture_signal = cap_sig_reg;

    // timebase prescaler for the capture counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 6'h00;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    always_comb begin
        case (ctrl_reg.clk_sel)
            cis_pkg::CIS_DIV64: div_mask = cis_pkg::DIV64_MASK;
            cis_pkg::CIS_DIV32: div_mask = cis_pkg::DIV32_MASK;
            cis_pkg::CIS_DIV2: div_mask = cis_pkg::DIV2_MASK;
            cis_pkg::CIS_DIV1: div_mask = cis_pkg::DIV1_MASK;
            default: div_mask = cis_pkg::DIV64_MASK;
        endcase
    end
    assign count_tick = ((pre_reg & div_mask) == div_mask);
    assign ovf_evt = count_tick && (count_reg == 8'hff);

    // hi clears on rising, lo on falling, both set gives both edges
    assign clr_evt = (rise_evt && ctrl_reg.counter_clear_select_hi)
                   || (fall_evt && ctrl_reg.counter_clear_select_lo);

    // counter: a clearing edge wins over an increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= cis_pkg::CNT_RST;
        end else if (clr_evt) begin
            count_reg <= cis_pkg::CNT_RST;
        end else if (count_tick) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // capture registers latch the count at each edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_rise_reg <= cis_pkg::CNT_RST;
            cap_fall_reg <= cis_pkg::CNT_RST;
        end else begin
            if (rise_evt) begin
                cap_rise_reg <= count_reg;
            end
            if (fall_evt) begin
                cap_fall_reg <= count_reg;
            end
        end
    end

    // apb decode: zero wait states, data registered in the setup cycle
    assign hit = reg_is(paddr, cis_pkg::CTRL_OFS)
              || reg_is(paddr, cis_pkg::STAT_OFS)
              || reg_is(paddr, cis_pkg::MASK_OFS)
              || reg_is(paddr, cis_pkg::CNT_OFS)
              || reg_is(paddr, cis_pkg::CAPR_OFS)
              || reg_is(paddr, cis_pkg::CAPF_OFS)
              || reg_is(paddr, cis_pkg::LVL_OFS);
    assign setup_rd = psel && !penable && !pwrite;
    assign acc = psel && penable;
    assign acc_wr = acc && pwrite && hit;
    assign stat_rd = acc && !pwrite && reg_is(paddr, cis_pkg::STAT_OFS);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            cis_pkg::CTRL_OFS: rdata_next[6:0] = ctrl_reg;
            cis_pkg::STAT_OFS: rdata_next[1:0] = stat_reg;
            cis_pkg::MASK_OFS: rdata_next[1:0] = mask_reg;
            cis_pkg::CNT_OFS: rdata_next[7:0] = count_reg;
            cis_pkg::CAPR_OFS: rdata_next[7:0] = cap_rise_reg;
            cis_pkg::CAPF_OFS: rdata_next[7:0] = cap_fall_reg;
            cis_pkg::LVL_OFS: rdata_next[1:0] = {pin_sync, cap_sig_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data comes from a flop loaded while the setup cycle stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= rdata_next;
        end
    end

    // control and mask registers, written in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= cis_pkg::CTRL_RST;
            mask_reg <= cis_pkg::MASK_RST;
        end else if (acc_wr) begin
            if (reg_is(paddr, cis_pkg::CTRL_OFS)) begin
                ctrl_reg <= pwdata[cis_pkg::CTRL_W-1:0];
            end
            if (reg_is(paddr, cis_pkg::MASK_OFS)) begin
                mask_reg <= pwdata[1:0];
            end
        end
    end

    // sticky status cleared by reading it; a new event wins the clear
    always_comb begin
        stat_next = stat_rd ? cis_pkg::STAT_RST : stat_reg;
        stat_next[cis_pkg::STAT_CAP_BIT] =
            stat_next[cis_pkg::STAT_CAP_BIT] | cap_evt;
        stat_next[cis_pkg::STAT_OVF_BIT] =
            stat_next[cis_pkg::STAT_OVF_BIT] | ovf_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= cis_pkg::STAT_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // level interrupt; masking is how software keeps false edges quiet
    assign irq = |(stat_reg & mask_reg);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_DESELECT_QUIET: assert property (
        !ctrl_reg.capture_pin_select && !$past(ctrl_reg.capture_pin_select)
        |-> !rise_evt && !fall_evt)
        else $error("edge seen while pin not selected");

    AST_GATE_LOW: assert property (
        !ctrl_reg.capture_pin_select |=> !capture_signal)
        else $error("capture signal high while deselected");

    AST_SEL_RISE: assert property (
        $rose(ctrl_reg.capture_pin_select) && src_lvl
        |-> rise_evt ##1 capture_signal)
        else $error("select rise with pin high gave no rising edge");

    AST_SEL_FALL: assert property (
        $fell(ctrl_reg.capture_pin_select) && $past(cap_sig_next)
        |-> fall_evt ##1 !capture_signal)
        else $error("select fall with pin high gave no falling edge");

    AST_SEL_EDGE: assert property (
        $changed(ctrl_reg.capture_pin_select) && src_lvl
        && $past(src_lvl) |-> rise_evt || fall_evt)
        else $error("select change not treated as an edge");

    AST_FILT_SWITCH: assert property (
        $changed(ctrl_reg.noise_filter_select)
        && ctrl_reg.capture_pin_select && $past(ctrl_reg.capture_pin_select)
        && src_lvl != capture_signal |-> rise_evt || fall_evt)
        else $error("filter switch edge lost");

    AST_FLAG_RISE: assert property (
        rise_evt && ctrl_reg.capture_irq_edge_select
        |=> stat_reg[cis_pkg::STAT_CAP_BIT])
        else $error("rising edge did not set capture flag");

    AST_FLAG_FALL: assert property (
        fall_evt && !ctrl_reg.capture_irq_edge_select
        |=> stat_reg[cis_pkg::STAT_CAP_BIT] ##1 $stable(cap_fall_reg)
        || fall_evt)
        else $error("falling edge did not set capture flag");

    AST_NO_WRONG_FLAG: assert property (
        !stat_reg[cis_pkg::STAT_CAP_BIT] && !cap_evt
        |=> !stat_reg[cis_pkg::STAT_CAP_BIT])
        else $error("capture flag set without matching edge");

    AST_CAPTURE_COUNT: assert property (
        rise_evt |=> cap_rise_reg == $past(count_reg))
        else $error("rising capture did not latch the count");

    AST_CLEAR_BOTH: assert property (
        ctrl_reg.counter_clear_select_hi && ctrl_reg.counter_clear_select_lo
        && (rise_evt || fall_evt) |=> count_reg == cis_pkg::CNT_RST)
        else $error("counter not cleared on edge");

    AST_IRQ_LEVEL: assert property (
        cap_evt && mask_reg[cis_pkg::STAT_CAP_BIT] && !acc_wr
        |=> irq ##1 (irq || $past(stat_rd) || $past(acc_wr)))
        else $error("unmasked capture flag did not raise irq");

    COV_SEL_RISE: cover property (
        $rose(ctrl_reg.capture_pin_select) ##0 rise_evt);
    COV_FILT_EDGE: cover property (
        ctrl_reg.noise_filter_select && ctrl_reg.capture_pin_select
        ##0 fall_evt);
    COV_SET_WINS: cover property (stat_rd && cap_evt);
    COV_IRQ: cover property ($rose(irq));
endmodule

// file: verif/cis_pin_src.sv
// stand-in for the outside source that drives the capture pin
// assumes the bench calls its tasks and shares the block's pclk
`timescale 1ns/10ps
module cis_pin_src (
    input wire logic pclk,
    output logic pin
);
    // pin is always driven; a real source never floats this input
    initial pin = 1'b0;

    // level change launched just after an edge, like any board signal
    task automatic set(input logic v);
        @(posedge pclk);
        pin <= v;
    endtask

    // short high glitch, used to check that the filter rejects it
    task automatic pulse(input int n);
        @(posedge pclk);
        pin <= 1'b1;
        repeat (n) @(posedge pclk);
        pin <= 1'b0;
    endtask
endmodule

// file: verif/capture_input_switch_edges_tb.sv
// self-checking bench for the capture input conditioning block
// assumes zero-wait apb answers and the pin source model beside it
`timescale 1ns/10ps
module capture_input_switch_edges_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic capture_signal, irq, pin, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares, comparisons;
    localparam logic [7:0] CTL = cis_pkg::CTRL_OFS;
    localparam logic [7:0] STA = cis_pkg::STAT_OFS;

    cis_capture dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shared_capture_port_pin(pin),
        .capture_signal(capture_signal), .irq(irq));
    cis_pin_src pin_u (.pclk(pclk), .pin(pin));

    // 200 mhz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // control word built from the packed carrier
    function automatic logic [31:0] ctl(logic s, logic f, logic e);
        cis_pkg::cis_ctrl_s c;
        c = '0;
        c.capture_pin_select = s;
        c.noise_filter_select = f;
        c.capture_irq_edge_select = e;
        return 32'(c);
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; the master waits for pready, never a fixed count
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // bounded wait for the capture level, then judge it; sampled on the
    // falling edge so a level launched at the rising edge has settled
    task wait_cs(input logic exp, input int lim);
        int n;
        n = 0;
        @(negedge pclk);
        while (capture_signal !== exp && n < lim) begin
            @(negedge pclk);
            n++;
        end
        check({31'h0, capture_signal}, {31'h0, exp});
    endtask

    task t_reset;
        for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check({rd[30:0], perr}, 32'h1); // unmapped: reads 0, error
        $display("test reset done");
    endtask

    task t_sel_rise;
        wr(cis_pkg::MASK_OFS, 32'h1);
        wr(CTL, ctl(1'b0, 1'b0, 1'b1));
        pin_u.set(1'b1);
        repeat (8) @(posedge pclk);
        check({31'h0, capture_signal}, 32'h0);
        rd_chk(STA, 32'h0);
        wr(CTL, ctl(1'b1, 1'b0, 1'b1));
        wait_cs(1'b1, 8);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        rd_chk(STA, 32'h1);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        $display("test select_rise done");
    endtask

    task t_sel_fall;
        wr(cis_pkg::MASK_OFS, 32'h0);
        wr(CTL, ctl(1'b1, 1'b0, 1'b0));
        wr(CTL, ctl(1'b0, 1'b0, 1'b0));
        wait_cs(1'b0, 8);
        repeat (4) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(STA, 32'h1);
        wr(cis_pkg::MASK_OFS, 32'h1);
        check({31'h0, irq}, 32'h0);
        $display("test select_fall done");
    endtask

    task t_pin;
        wr(CTL, ctl(1'b1, 1'b0, 1'b1));
        apb(1'b0, STA, 32'h0);
        pin_u.set(1'b0);
        wait_cs(1'b0, 8);
        rd_chk(STA, 32'h0);
        pin_u.set(1'b1);
        wait_cs(1'b1, 8);
        rd_chk(STA, 32'h1);
        $display("test pin_edges done");
    endtask

    // filter settling, delay and noise rejection
    task t_filt;
        wr(CTL, ctl(1'b0, 1'b0, 1'b1));
        wr(CTL, ctl(1'b0, 1'b1, 1'b1));
        wr(CTL, ctl(1'b1, 1'b1, 1'b1));
        wait_cs(1'b1, 8);
        rd_chk(STA, 32'h1);
        repeat (48) @(posedge pclk);
        wr(CTL, ctl(1'b0, 1'b1, 1'b0));
        wait_cs(1'b0, 8);
        rd_chk(STA, 32'h1);
        wr(CTL, ctl(1'b1, 1'b1, 1'b1));
        wait_cs(1'b1, 60);
        apb(1'b0, STA, 32'h0);
        pin_u.set(1'b0);
        repeat (30) @(posedge pclk);
        check({31'h0, capture_signal}, 32'h1);
        wait_cs(1'b0, 30);
        pin_u.pulse(16);
        repeat (60) @(posedge pclk);
        check({31'h0, capture_signal}, 32'h0);
        rd_chk(STA, 32'h0);
        $display("test filter done");
    endtask

    // filter switched while an edge is still settling
    task t_fswitch;
        wr(CTL, ctl(1'b0, 1'b0, 1'b1));
        wr(CTL, ctl(1'b1, 1'b0, 1'b1));
        apb(1'b0, STA, 32'h0);
        pin_u.set(1'b1);
        wr(CTL, ctl(1'b1, 1'b1, 1'b1));
        wait_cs(1'b1, 60);
        rd_chk(STA, 32'h1);
        wr(CTL, ctl(1'b1, 1'b1, 1'b0));
        pin_u.set(1'b0);
        wr(CTL, ctl(1'b1, 1'b0, 1'b0));
        wait_cs(1'b0, 8);
        rd_chk(STA, 32'h1);
        $display("test filter_switch done");
    endtask

    // both clear selects, undivided count: each pin edge restarts it
    task t_clear;
        wr(CTL, 32'h79);
        pin_u.set(1'b1);
        wait_cs(1'b1, 8);
        apb(1'b0, cis_pkg::CNT_OFS, 32'h0);
        check({31'h0, rd[7:0] < 8'h10}, 32'h1);
        repeat (50) @(posedge pclk);
        pin_u.set(1'b0);
        wait_cs(1'b0, 8);
        apb(1'b0, cis_pkg::CNT_OFS, 32'h0);
        check({31'h0, rd[7:0] < 8'h10}, 32'h1);
        $display("test clear_both done");
    endtask

    task tally_and_finish;
        $display("comparisons=%0d miscompares=%0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence; reset held 20 cycles
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_sel_rise;
        t_sel_fall;
        t_pin;
        t_filt;
        t_fswitch;
        t_clear;
        tally_and_finish;
    end

    // tests need well under a thousand cycles; this only cuts a hang
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        tally_and_finish;
    end
endmodule
